/* File: verilog/com_cfg.svh */
// Operation
// - Each receive buffer shows a read-only byte with the low eight extended identifier bits of its frame.
// - The length field gives 0 to 8 payload bytes as binary 0000 to 1000, and 1001 to 1111 are flagged invalid.
// - Normal mode watches all bus traffic and drives acknowledge and error frames.
// - Frames go out on the bus only in normal mode.
// - Listen-only mode receives every frame, those with errors too.
// - Listen-only mode sends nothing, no error flags and no acknowledges.
// - Entering listen-only clears both error counters and holds them there for the whole mode.
// - Filtering still applies in silent modes, and an all-zero mask passes any identifier.
// - Loopback routes transmit buffers straight into the receive path, not onto the bus.
// - Loopback needs no acknowledge and takes its own frames like any other node's.
// - Loopback sends nothing, no error flags and no acknowledges.
// - In loopback the transmit pin is handed back to ordinary port control.
// - Software picks listen-only or loopback through the mode-request field and the controller follows.
// - Accept mode 11 in a receive buffer makes it ignore errors and accept any frame that passes the filter.
// - In error recognition an error copies the assembly buffer contents into the receive buffer.
// - Every reset starts in functional mode 0.
`ifndef COM_CFG_SVH
`define COM_CFG_SVH
`define COM_OFF_MODE     8'h00
`define COM_OFF_RXCTL    8'h04
`define COM_OFF_MASK     8'h08
`define COM_OFF_FILT     8'h0C
`define COM_OFF_EIDL     8'h10
`define COM_OFF_LEN      8'h14
`define COM_OFF_TXQ      8'h18
`define COM_OFF_ERRCNT   8'h1C
`define COM_REQ_LISTEN   2'h1
`define COM_REQ_LOOP     2'h2
`define COM_ACC_ALL      2'h3
`define COM_LEN_MAX      4'h8
`define COM_FUNC_MODE    2'h0
`define COM_RST_REQ      2'h0
`define COM_RST_ACC      2'h0
`define COM_RST_MASK     8'h00
`define COM_RST_FILT     8'h00
`define COM_BIT_FULL     0
`define COM_BIT_ERRCAP   1
`define COM_BIT_BADLEN   2
`define COM_POS_ACC      5
`define COM_POS_CUR      4
`define COM_POS_FUNC     8
`define COM_POS_TXLEN    8
`define COM_POS_REC      8
`endif

/* File: verilog/com_pkg.sv */
package com_pkg;
  typedef struct packed
  {
    logic [3:0] len;
    logic [7:0] id_low;
  } com_frame_t;

  typedef enum logic [1:0]
  {
    com_normal,
    com_listen,
    com_loopback
  } com_mode_t;
endpackage

/* File: verilog/com_ctrl.sv */
`timescale 1ns/100ps
`include "com_cfg.svh"

module com_fifo #(
  parameter int W = 12,
  parameter int D = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [CW-1:0] cnt;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt != CW'(D));
  assign out_valid = (cnt != '0);
  assign out_data  = mem[rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge pclk)
  begin
    if (push)
      mem[wp] <= in_data;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wp <= '0;
      rp <= '0;
    end
    else
    begin
      if (push)
        wp <= (wp == AW'(D - 1)) ? '0 : wp + 1'b1;
      if (pop)
        rp <= (rp == AW'(D - 1)) ? '0 : rp + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt <= '0;
    else if (push && !pop)
      cnt <= cnt + 1'b1;
    else if (pop && !push)
      cnt <= cnt - 1'b1;
  end
endmodule

module com_ctrl #(
  parameter int TXQ_DEPTH = 4
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               rx_frame_valid,
  input  wire com_pkg::com_frame_t rx_frame,
  input  wire logic               rx_frame_error,
  input  wire logic               ack_request,
  input  wire logic               error_request,
  input  wire logic               tec_inc,
  input  wire logic               rec_inc,
  input  wire logic               tx_frame_ready,
  output logic                    tx_frame_valid,
  output com_pkg::com_frame_t     tx_frame,
  output logic                    ack_drive,
  output logic                    error_flag_drive,
  output logic                    tx_pin_own,
  output logic [1:0]              functional_mode
);
  logic [1:0]          mode_req;
  com_pkg::com_mode_t  mode;
  com_pkg::com_mode_t  next_mode;
  logic [1:0]          accept_mode;
  logic [7:0]          mask;
  logic [7:0]          filt;
  logic [7:0]          ext_id_low_bits;
  logic [3:0]          payload_length_field;
  logic                full;
  logic                err_cap;
  logic [7:0]          tec;
  logic [7:0]          rec;
  logic                acc;
  logic                wr_en;
  logic                txq_req;
  logic                q_in_ready;
  logic                q_out_valid;
  logic                q_out_ready;
  com_pkg::com_frame_t q_out;
  com_pkg::com_frame_t src;
  logic                loop_pop;
  logic                rx_in;
  logic                rx_err;
  logic                pass;
  logic                err_ok;
  logic                commit;
  logic                bad_len;
  logic [31:0]         next_rdata;

  function automatic logic mapped(input logic [7:0] a);
    return (a == `COM_OFF_MODE) || (a == `COM_OFF_RXCTL) || (a == `COM_OFF_MASK) ||
           (a == `COM_OFF_FILT) || (a == `COM_OFF_EIDL) || (a == `COM_OFF_LEN) ||
           (a == `COM_OFF_TXQ) || (a == `COM_OFF_ERRCNT);
  endfunction

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    return (v == 8'hFF) ? v : v + 8'h01;
  endfunction

  // Bus slave: stalls only while the transmit queue is full
  assign acc     = psel & penable;
  assign txq_req = acc & pwrite & (paddr == `COM_OFF_TXQ);
  assign pready  = !(txq_req && !q_in_ready);
  assign pslverr = acc & !mapped(paddr);
  assign wr_en   = acc & pwrite & pready;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_req    <= `COM_RST_REQ;
      accept_mode <= `COM_RST_ACC;
      mask        <= `COM_RST_MASK;
      filt        <= `COM_RST_FILT;
    end
    else if (wr_en)
    begin
      if (paddr == `COM_OFF_MODE)
        mode_req <= pwdata[1:0];
      else if (paddr == `COM_OFF_RXCTL)
        accept_mode <= pwdata[`COM_POS_ACC+1:`COM_POS_ACC];
      else if (paddr == `COM_OFF_MASK)
        mask <= pwdata[7:0];
      else if (paddr == `COM_OFF_FILT)
        filt <= pwdata[7:0];
    end
  end

  // Mode follows the request one cycle later
  always_comb
  begin
    case (mode_req)
      `COM_REQ_LISTEN: next_mode = com_pkg::com_listen;
      `COM_REQ_LOOP:   next_mode = com_pkg::com_loopback;
      default:         next_mode = com_pkg::com_normal;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode <= com_pkg::com_normal;
    else
      mode <= next_mode;
  end

  assign functional_mode = `COM_FUNC_MODE;

  com_fifo #(
    .W ($bits(com_pkg::com_frame_t)),
    .D (TXQ_DEPTH)
  ) u_txq (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (txq_req),
    .in_ready  (q_in_ready),
    .in_data   ({pwdata[`COM_POS_TXLEN+3:`COM_POS_TXLEN], pwdata[7:0]}),
    .out_valid (q_out_valid),
    .out_ready (q_out_ready),
    .out_data  (q_out)
  );

  // Transmit path: bus only in normal, internal in loopback, held in listen
  assign tx_frame_valid = q_out_valid & (mode == com_pkg::com_normal);
  assign tx_frame       = q_out;
  assign loop_pop       = q_out_valid & (mode == com_pkg::com_loopback);
  assign q_out_ready    = (mode == com_pkg::com_normal) ? tx_frame_ready :
                          (mode == com_pkg::com_loopback);
  assign ack_drive        = ack_request & (mode == com_pkg::com_normal);
  assign error_flag_drive = error_request & (mode == com_pkg::com_normal);
  assign tx_pin_own       = (mode != com_pkg::com_loopback);

  // Receive path and acceptance
  assign src    = loop_pop ? q_out : rx_frame;
  assign rx_in  = loop_pop | (rx_frame_valid & (mode != com_pkg::com_loopback));
  assign rx_err = !loop_pop & rx_frame_error;
  assign pass   = ((src.id_low ^ filt) & mask) == 8'h00;
  assign err_ok = !rx_err || (mode == com_pkg::com_listen) || (accept_mode == `COM_ACC_ALL);
  assign commit = rx_in & pass & err_ok;
  assign bad_len = (payload_length_field > `COM_LEN_MAX);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_id_low_bits      <= 8'h00;
      payload_length_field <= 4'h0;
      err_cap              <= 1'b0;
    end
    else if (commit)
    begin
      ext_id_low_bits      <= src.id_low;
      payload_length_field <= src.len;
      err_cap              <= rx_err;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      full <= 1'b0;
    else if (commit)
      full <= 1'b1;
    else if (wr_en && (paddr == `COM_OFF_RXCTL) && pwdata[`COM_BIT_FULL])
      full <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tec <= 8'h00;
      rec <= 8'h00;
    end
    else if (mode == com_pkg::com_listen)
    begin
      tec <= 8'h00;
      rec <= 8'h00;
    end
    else
    begin
      if (tec_inc)
        tec <= sat_inc(tec);
      if (rec_inc)
        rec <= sat_inc(rec);
    end
  end

  // Read data latched in the setup cycle
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (paddr == `COM_OFF_MODE)
    begin
      next_rdata[1:0]                       = mode_req;
      next_rdata[`COM_POS_CUR+1:`COM_POS_CUR] = mode;
      next_rdata[`COM_POS_FUNC+1:`COM_POS_FUNC] = functional_mode;
    end
    else if (paddr == `COM_OFF_RXCTL)
    begin
      next_rdata[`COM_POS_ACC+1:`COM_POS_ACC] = accept_mode;
      next_rdata[`COM_BIT_FULL]   = full;
      next_rdata[`COM_BIT_ERRCAP] = err_cap;
      next_rdata[`COM_BIT_BADLEN] = bad_len;
    end
    else if (paddr == `COM_OFF_MASK)
      next_rdata[7:0] = mask;
    else if (paddr == `COM_OFF_FILT)
      next_rdata[7:0] = filt;
    else if (paddr == `COM_OFF_EIDL)
      next_rdata[7:0] = ext_id_low_bits;
    else if (paddr == `COM_OFF_LEN)
      next_rdata[3:0] = payload_length_field;
    else if (paddr == `COM_OFF_ERRCNT)
    begin
      next_rdata[7:0]                       = tec;
      next_rdata[`COM_POS_REC+7:`COM_POS_REC] = rec;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= next_rdata;
  end

  property p_tx_normal_only;
    @(posedge pclk) disable iff (!presetn)
      tx_frame_valid |-> (mode == com_pkg::com_normal) && tx_pin_own;
  endproperty
  a_tx_normal_only: assert property (p_tx_normal_only) else $error("frame offered outside normal mode");

  property p_silent;
    @(posedge pclk) disable iff (!presetn)
      (mode != com_pkg::com_normal) |-> !ack_drive && !error_flag_drive;
  endproperty
  a_silent: assert property (p_silent) else $error("silent mode drove ack or error");

  property p_normal_ack;
    @(posedge pclk) disable iff (!presetn)
      (mode == com_pkg::com_normal) |-> (ack_drive == ack_request) && (error_flag_drive == error_request);
  endproperty
  a_normal_ack: assert property (p_normal_ack) else $error("normal mode did not drive ack or error");

  property p_listen_counters;
    @(posedge pclk) disable iff (!presetn)
      (mode == com_pkg::com_listen) ##1 (mode == com_pkg::com_listen) |-> (tec == 8'h00) && (rec == 8'h00);
  endproperty
  a_listen_counters: assert property (p_listen_counters) else $error("error counter moved in listen-only");

  property p_loop_pin;
    @(posedge pclk) disable iff (!presetn)
      (mode == com_pkg::com_loopback) |-> !tx_pin_own && !tx_frame_valid;
  endproperty
  a_loop_pin: assert property (p_loop_pin) else $error("pin kept in loopback");

  property p_loop_commit;
    @(posedge pclk) disable iff (!presetn)
      (loop_pop && ((q_out.id_low ^ filt) & mask) == 8'h00) |=>
        full && (ext_id_low_bits == $past(q_out.id_low)) && (payload_length_field == $past(q_out.len));
  endproperty
  a_loop_commit: assert property (p_loop_commit) else $error("looped frame not stored");

  property p_mode_follow;
    @(posedge pclk) disable iff (!presetn)
      $changed(mode_req) && (mode_req == `COM_REQ_LISTEN) |=> (mode == com_pkg::com_listen);
  endproperty
  a_mode_follow: assert property (p_mode_follow) else $error("listen-only request not followed");

  property p_err_recog;
    @(posedge pclk) disable iff (!presetn)
      (rx_frame_valid && rx_frame_error && (mode == com_pkg::com_normal) && (accept_mode == `COM_ACC_ALL) &&
       ((rx_frame.id_low ^ filt) & mask) == 8'h00) |=> full && err_cap && (ext_id_low_bits == $past(rx_frame.id_low));
  endproperty
  a_err_recog: assert property (p_err_recog) else $error("assembly contents not copied on error");

  property p_err_drop;
    @(posedge pclk) disable iff (!presetn)
      (rx_frame_valid && rx_frame_error && (mode == com_pkg::com_normal) && (accept_mode != `COM_ACC_ALL))
        |=> $stable(ext_id_low_bits) && $stable(payload_length_field);
  endproperty
  a_err_drop: assert property (p_err_drop) else $error("errored frame stored without accept-all");

  property p_bad_len;
    @(posedge pclk) disable iff (!presetn)
      commit ##1 1'b1 |-> (bad_len == ($past(src.len) > `COM_LEN_MAX));
  endproperty
  a_bad_len: assert property (p_bad_len) else $error("length validity wrong");

  property p_commit_whole;
    @(posedge pclk) disable iff (!presetn)
      commit |=> full && (ext_id_low_bits == $past(src.id_low)) && (payload_length_field == $past(src.len));
  endproperty
  a_commit_whole: assert property (p_commit_whole) else $error("committed frame not stored whole");

  property p_listen_hold;
    @(posedge pclk) disable iff (!presetn)
      (mode == com_pkg::com_listen) |-> !q_out_ready && !tx_frame_valid;
  endproperty
  a_listen_hold: assert property (p_listen_hold) else $error("frame left the queue in listen-only");
endmodule

/* File: sim/com_can_node.sv */
`timescale 1ns/100ps

module com_can_node (
  input  wire logic           pclk,
  output logic                rx_frame_valid,
  output com_pkg::com_frame_t rx_frame,
  output logic                rx_frame_error,
  output logic                ack_request,
  output logic                error_request,
  output logic                tec_inc,
  output logic                rec_inc,
  output logic                tx_frame_ready
);
  logic stall;

  initial
  begin
    stall = 1'b0;
    rx_frame_valid = 1'b0;
    rx_frame = '0;
    rx_frame_error = 1'b0;
    ack_request = 1'b0;
    error_request = 1'b0;
    tec_inc = 1'b0;
    rec_inc = 1'b0;
  end

  // Slow node holds off taking frames
  assign tx_frame_ready = !stall;

  // One frame from the bus, lines scrambled once released
  task automatic send(input logic [7:0] id, input logic [3:0] len, input logic err);
    @(posedge pclk);
    rx_frame_valid <= 1'b1;
    rx_frame <= {len, id};
    rx_frame_error <= err;
    @(posedge pclk);
    rx_frame_valid <= 1'b0;
    rx_frame <= ~{len, id};
    rx_frame_error <= ~err;
  endtask

  // Flow control and engine requests, changed just after an edge
  task automatic hold(input logic st, input logic ack, input logic err);
    @(posedge pclk);
    stall <= st;
    ack_request <= ack;
    error_request <= err;
  endtask

  task automatic pulse(input logic tx, input logic rx);
    @(posedge pclk);
    tec_inc <= tx;
    rec_inc <= rx;
    @(posedge pclk);
    tec_inc <= 1'b0;
    rec_inc <= 1'b0;
  endtask
endmodule

/* File: sim/com_ctrl_tb.sv */
`timescale 1ns/100ps
`include "com_cfg.svh"
`define chk(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; $display("mismatch %0t: %h vs %h", $time, (a), (e)); end end

module com_ctrl_tb;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [7:0]          paddr = '0;
  logic [31:0]         pwdata = '0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                rx_frame_valid;
  com_pkg::com_frame_t rx_frame;
  logic                rx_frame_error;
  logic                ack_request;
  logic                error_request;
  logic                tec_inc;
  logic                rec_inc;
  logic                tx_frame_ready;
  logic                tx_frame_valid;
  com_pkg::com_frame_t tx_frame;
  logic                ack_drive;
  logic                error_flag_drive;
  logic                tx_pin_own;
  logic [1:0]          functional_mode;
  int                  num_errors = 0;
  int                  total_checks = 0;
  int                  waits;
  logic [32:0]         rq[$];
  com_pkg::com_frame_t tq[$];
  logic [7:0]          id;

  always #2 pclk = ~pclk;

  com_ctrl #(.TXQ_DEPTH(4)) i_com_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame), .rx_frame_error(rx_frame_error),
    .ack_request(ack_request), .error_request(error_request), .tec_inc(tec_inc), .rec_inc(rec_inc),
    .tx_frame_ready(tx_frame_ready), .tx_frame_valid(tx_frame_valid), .tx_frame(tx_frame),
    .ack_drive(ack_drive), .error_flag_drive(error_flag_drive), .tx_pin_own(tx_pin_own),
    .functional_mode(functional_mode));

  com_can_node i_com_can_node (.pclk(pclk), .rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame),
    .rx_frame_error(rx_frame_error), .ack_request(ack_request), .error_request(error_request),
    .tec_inc(tec_inc), .rec_inc(rec_inc), .tx_frame_ready(tx_frame_ready));

  // Read results against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
      `chk({pslverr, prdata}, rq.pop_front())

  // Frames taken by the node against the oldest note
  always @(posedge pclk)
    if (tx_frame_valid && tx_frame_ready)
      `chk(tx_frame, tq.pop_front())

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    waits = n;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #(4 * 20000);
    num_errors++;
    close_out();
  end

  initial
  begin
    void'($urandom(32'hAC21));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(`COM_OFF_MODE, 33'h0);
    `chk(functional_mode, 2'h0)
    rd(`COM_OFF_MASK, 33'h0);
    rd(`COM_OFF_ERRCNT, 33'h0);
    rd(8'h20, {1'b1, 32'h0});
    $display("test reset done");
    for (int i = 0; i < 16; i++)
    begin
      id = 8'($urandom());
      i_com_can_node.send(id, 4'(i), 1'b0);
      rd(`COM_OFF_EIDL, {25'h0, id});
      rd(`COM_OFF_LEN, 33'(i));
      rd(`COM_OFF_RXCTL, {30'h0, i > 8, 2'h1});
      apb(1'b1, `COM_OFF_RXCTL, 32'h1);
    end
    apb(1'b1, `COM_OFF_EIDL, 32'hFF);
    rd(`COM_OFF_EIDL, {25'h0, id});
    $display("test length done");
    apb(1'b1, `COM_OFF_MASK, 32'hFF);
    apb(1'b1, `COM_OFF_FILT, 32'h5A);
    i_com_can_node.send(8'h5A, 4'h2, 1'b0);
    i_com_can_node.send(8'h5B, 4'h3, 1'b0);
    i_com_can_node.send(8'h5A, 4'h4, 1'b1);
    rd(`COM_OFF_LEN, 33'h2);
    apb(1'b1, `COM_OFF_MASK, 32'h0);
    apb(1'b1, `COM_OFF_RXCTL, {25'h0, `COM_ACC_ALL, 5'h1});
    i_com_can_node.send(8'h33, 4'hF, 1'b1);
    rd(`COM_OFF_RXCTL, 33'h67);
    rd(`COM_OFF_EIDL, 33'h33);
    apb(1'b1, `COM_OFF_RXCTL, 32'h1);
    $display("test filter done");
    i_com_can_node.hold(1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 5; i++)
      tq.push_back({4'(i), 8'($urandom())});
    for (int i = 0; i < 4; i++)
      apb(1'b1, `COM_OFF_TXQ, 32'(tq[i]));
    `chk(ack_drive & error_flag_drive, 1'b1)
    fork
      apb(1'b1, `COM_OFF_TXQ, 32'(tq[4]));
      begin
        repeat (20) @(posedge pclk);
        i_com_can_node.hold(1'b0, 1'b1, 1'b1);
      end
    join
    `chk(waits > 1, 1'b1)
    repeat (8) @(posedge pclk);
    `chk(tq.size(), 0)
    $display("test transmit done");
    i_com_can_node.pulse(1'b1, 1'b1);
    i_com_can_node.pulse(1'b1, 1'b0);
    rd(`COM_OFF_ERRCNT, 33'h0102);
    apb(1'b1, `COM_OFF_MODE, {30'h0, `COM_REQ_LISTEN});
    rd(`COM_OFF_MODE, 33'h11);
    i_com_can_node.pulse(1'b1, 1'b1);
    rd(`COM_OFF_ERRCNT, 33'h0);
    `chk({ack_drive, error_flag_drive}, 2'b00)
    i_com_can_node.send(8'h77, 4'h1, 1'b1);
    rd(`COM_OFF_RXCTL, 33'h3);
    apb(1'b1, `COM_OFF_RXCTL, 32'h1);
    tq.push_back({4'h5, 8'h3C});
    apb(1'b1, `COM_OFF_TXQ, 32'h53C);
    @(posedge pclk);
    `chk(tx_frame_valid, 1'b0)
    apb(1'b1, `COM_OFF_MODE, 32'h0);
    repeat (4) @(posedge pclk);
    `chk(tq.size(), 0)
    $display("test listen done");
    apb(1'b1, `COM_OFF_MODE, {30'h0, `COM_REQ_LOOP});
    rd(`COM_OFF_MODE, 33'h22);
    `chk(tx_pin_own, 1'b0)
    `chk({ack_drive, error_flag_drive}, 2'b00)
    id = 8'($urandom());
    apb(1'b1, `COM_OFF_TXQ, {20'h0, 4'h6, id});
    @(posedge pclk);
    `chk(tx_frame_valid, 1'b0)
    repeat (3) @(posedge pclk);
    rd(`COM_OFF_EIDL, {25'h0, id});
    rd(`COM_OFF_LEN, 33'h6);
    apb(1'b1, `COM_OFF_MODE, 32'h0);
    repeat (2) @(posedge pclk);
    `chk(tx_pin_own, 1'b1)
    $display("test loopback done");
    repeat (4) @(posedge pclk);
    `chk(rq.size(), 0)
    close_out();
  end
endmodule
